//--- hdl/scan_seq_pkg.sv
package scan_seq_pkg;

  localparam int unsigned CLK_HZ        = 250_000_000;
  localparam int unsigned LIST_MAX      = 40;
  localparam int unsigned IDX_W         = 6;
  localparam int unsigned CHAN_W        = 8;
  localparam int unsigned CNT_W         = 17;
  localparam int unsigned TIME_W        = 48;

  // tick base: all delays count in 1 ms steps
  localparam int unsigned TICK_NS       = 1_000_000;
  localparam int unsigned TICK_CYC      = TICK_NS / 4;
  localparam int unsigned TICK_W        = 18;
  localparam logic [TIME_W-1:0] TIMER_MAX_MS = 48'h003b9ac9ff; // 999999.999 s
  localparam logic [TIME_W-1:0] RATIO_MAX_MS = 48'h003b9ac9ff; // 999999.999 s
  localparam logic [TIME_W-1:0] RATIO_DEF_MS = 48'h00000001f4; // 0.5 s
  // 99 h 99 min 99.999 s
  localparam logic [TIME_W-1:0] MANUAL_MAX_MS = 48'h00159a653f;

  // APB map, byte addresses
  localparam logic [7:0] A_CTRL    = 8'h00;
  localparam logic [7:0] A_STATUS  = 8'h04;
  localparam logic [7:0] A_RDGCNT  = 8'h08;
  localparam logic [7:0] A_LISTLEN = 8'h0c;
  localparam logic [7:0] A_TIMER   = 8'h10;
  localparam logic [7:0] A_MDELAY  = 8'h14;
  localparam logic [7:0] A_ADELAY  = 8'h18;
  localparam logic [7:0] A_RDELAY  = 8'h1c;
  localparam logic [7:0] A_LIST    = 8'h40;  // entries 0x40..0xdc

  // CTRL field positions
  localparam int unsigned C_START   = 0;
  localparam int unsigned C_STOP    = 1;
  localparam int unsigned C_FULL    = 2;
  localparam int unsigned C_SRC     = 3;  // 2 bits
  localparam int unsigned C_MANUAL  = 5;
  localparam int unsigned C_RATIO   = 6;
  localparam int unsigned C_FILTER  = 7;
  localparam int unsigned C_MTRIG   = 8;

  localparam logic [1:0] SRC_IMM   = 2'h0;
  localparam logic [1:0] SRC_TIMER = 2'h1;
  localparam logic [1:0] SRC_EXT   = 2'h2;

  typedef enum {ST_IDLE, ST_SOURCE, ST_TIMER, ST_DELAY, ST_RDELAY, ST_MEAS, ST_STORE}
    seq_state_e;

  typedef struct packed {
    logic [CHAN_W-1:0] chan;
    logic              close;
  } relay_s;

endpackage

//--- hdl/scan_trigger_sequencer.sv
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - start: pass mode closes first channel, wait trigger
// - step: store, pulse, move closed relay to next channel, wait
// - done: idle, halt, first channel closed in pass mode
// - pass mode: loop list, pulse at end
// - further passes wait for new event
// - idle drops straight to source wait
// - three sources; immediate passes at once
// - event gives one channel or one pass
// - timer source: first pass bypasses timer
// - later passes wait max(timer, delay)
// - timer 0..999999.999 s, reset at end
// - timer paces channels or passes by mode
// - external: wait pin or manual key
// - auto delay fixed per function/range
// - manual delay up to 99h99m99.999s
// - timer source: delay on every pass, inside the max on later passes
// - ratio delay 0.5 s default, after delay
// - measure, then filter if enabled, store
// - step counter from count; resume next
// - unbounded count runs until stopped
// - pass: samples=list, triggers=ceil(count/list)
// - 40 entries in listed order, backward allowed
module scan_trigger_sequencer
(
  input  wire logic                      SYS_CLK,
  input  wire logic                      RST,
  input  wire logic [7:0]                PADDR,
  input  wire logic                      PSEL,
  input  wire logic                      PENABLE,
  input  wire logic                      PWRITE,
  input  wire logic [31:0]               PWDATA,
  output logic      [31:0]               PRDATA,
  output logic                           PREADY,
  output logic                           PSLVERR,
  input  wire logic                      EXT_MANUAL_TRIGGER_KEY,
  output logic                           OUT_MANUAL_TRIGGER_KEY,
  output scan_seq_pkg::relay_s           RELAY,
  output logic                           MEAS_START,
  output logic                           FILTER_START,
  input  wire logic                      MEAS_DONE,
  output logic                           STORE
);
  import scan_seq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [CHAN_W-1:0] list_mem [LIST_MAX];
  logic              full_pass, manual_dly, ratio_en, filter_en;
  logic [1:0]        src;
  logic [CNT_W-1:0]  rdg_count;
  logic [IDX_W-1:0]  list_len;
  logic [TIME_W-1:0] timer_ms, manual_ms, auto_ms, ratio_ms;
  logic              start_req, stop_req, mtrig_req;
  logic              wr, rd;
  seq_state_e        state;
  logic [IDX_W-1:0]  idx, sample;
  logic [CNT_W-1:0]  manual_trigger_key_left;
  logic              unbounded_count;
  logic              first_pass;
  logic              busy;

  assign wr      = PSEL && PENABLE && PWRITE;
  assign rd      = PSEL && !PWRITE;
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !(PADDR < A_LIST + 8'(LIST_MAX * 4)) ;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      full_pass  <= 1'b0;
      src        <= SRC_IMM;
      manual_dly <= 1'b0;
      ratio_en   <= 1'b0;
      filter_en  <= 1'b0;
      rdg_count  <= '0;
      list_len   <= 6'h01;
      timer_ms   <= '0;
      manual_ms  <= '0;
      auto_ms    <= '0;
      ratio_ms   <= RATIO_DEF_MS;
    end else if (wr) begin
      case (PADDR)
        A_CTRL: begin
          full_pass  <= PWDATA[C_FULL];
          src        <= PWDATA[C_SRC +: 2];
          manual_dly <= PWDATA[C_MANUAL];
          ratio_en   <= PWDATA[C_RATIO];
          filter_en  <= PWDATA[C_FILTER];
        end
        A_RDGCNT:  rdg_count <= PWDATA[CNT_W-1:0];
        A_LISTLEN: begin
          if (PWDATA != 32'h0 && PWDATA <= 32'(LIST_MAX)) begin
            list_len <= PWDATA[IDX_W-1:0];
          end
        end
        A_TIMER: begin
          timer_ms <= ({16'h0, PWDATA} > TIMER_MAX_MS) ? TIMER_MAX_MS : {16'h0, PWDATA};
        end
        A_MDELAY: begin
          manual_ms <= ({16'h0, PWDATA} > MANUAL_MAX_MS) ? MANUAL_MAX_MS : {16'h0, PWDATA};
        end
        A_ADELAY: auto_ms <= {16'h0, PWDATA};
        A_RDELAY: begin
          ratio_ms <= ({16'h0, PWDATA} > RATIO_MAX_MS) ? RATIO_MAX_MS : {16'h0, PWDATA};
        end
        default: ;
      endcase
    end
  end

  // scan list memory, entries visited strictly in stored order
  always_ff @(posedge SYS_CLK) begin
    if (wr && PADDR >= A_LIST && PADDR < A_LIST + 8'(LIST_MAX * 4)) begin
      list_mem[6'((PADDR - A_LIST) >> 2)] <= PWDATA[CHAN_W-1:0];
    end
  end

  // command strobes, one cycle each
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      start_req <= 1'b0;
      stop_req  <= 1'b0;
      mtrig_req <= 1'b0;
    end else begin
      start_req <= wr && PADDR == A_CTRL && PWDATA[C_START];
      stop_req  <= wr && PADDR == A_CTRL && PWDATA[C_STOP];
      mtrig_req <= wr && PADDR == A_CTRL && PWDATA[C_MTRIG];
    end
  end

  always_comb begin
    PRDATA = 32'h0;
    if (rd) begin
      case (PADDR)
        A_CTRL:    PRDATA = {24'h0, filter_en, ratio_en, manual_dly, src, full_pass, 2'h0};
        A_STATUS:  PRDATA = {8'h0, 2'h0, idx, manual_trigger_key_left[14:0], busy};
        A_RDGCNT:  PRDATA = {15'h0, rdg_count};
        A_LISTLEN: PRDATA = {26'h0, list_len};
        A_TIMER:   PRDATA = timer_ms[31:0];
        A_MDELAY:  PRDATA = manual_ms[31:0];
        A_ADELAY:  PRDATA = auto_ms[31:0];
        A_RDELAY:  PRDATA = ratio_ms[31:0];
        default:   PRDATA = 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // external trigger sync and edge
  logic ext_m, ext_s, ext_d, ext_evt;
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ext_m <= 1'b0;
      ext_s <= 1'b0;
      ext_d <= 1'b0;
    end else begin
      ext_m <= EXT_MANUAL_TRIGGER_KEY;
      ext_s <= ext_m;
      ext_d <= ext_s;
    end
  end
  assign ext_evt = ext_s && !ext_d;

  // 1 ms tick divider
  logic [TICK_W-1:0] tick_cnt;
  logic              tick;
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
    end
  end
  assign tick = tick_cnt == TICK_W'(TICK_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  logic              event_ok;
  logic [TIME_W-1:0] user_ms, wait_ms, dly_cnt;
  logic              last_in_list, count_done;
  logic [CNT_W-1:0]  manual_trigger_key_load;
  logic [IDX_W-1:0]  next_idx;

  assign user_ms = manual_dly ? manual_ms : auto_ms;
  // timer supersedes the delay only when longer
  assign wait_ms = (timer_ms > user_ms) ? timer_ms : user_ms;

  always_comb begin
    case (src)
      SRC_EXT: event_ok = ext_evt || mtrig_req;
      default: event_ok = 1'b1;
    endcase
  end

  assign last_in_list    = idx == list_len - 1'b1;
  assign next_idx        = last_in_list ? '0 : idx + 1'b1;
  assign unbounded_count = rdg_count == '0;
  // ceil(count/len) passes, or count steps
  assign manual_trigger_key_load = full_pass ?
                     CNT_W'((rdg_count + CNT_W'(list_len) - 1'b1) / CNT_W'(list_len)) :
                     rdg_count;
  assign count_done = !unbounded_count && manual_trigger_key_left == CNT_W'(1);
  assign busy = state != ST_IDLE;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      state      <= ST_IDLE;
      idx        <= '0;
      sample     <= '0;
      manual_trigger_key_left  <= '0;
      first_pass <= 1'b1;
      dly_cnt    <= '0;
    end else if (stop_req) begin
      state      <= ST_IDLE;
      idx        <= '0;
      first_pass <= 1'b1;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start_req) begin
            state      <= ST_SOURCE;
            manual_trigger_key_left  <= manual_trigger_key_load;
            sample     <= list_len;
            first_pass <= 1'b1;
            if (full_pass) begin
              idx <= '0;
            end
          end
        end
        ST_SOURCE: begin
          if (event_ok) begin
            // first pass skips timer; later passes take the longer wait
            if (src == SRC_TIMER && !first_pass) begin
              state   <= ST_TIMER;
              dly_cnt <= wait_ms;
            end else begin
              state   <= ST_DELAY;
              dly_cnt <= user_ms;
            end
          end
        end
        ST_TIMER, ST_DELAY: begin
          if (dly_cnt == '0) begin
            state   <= ratio_en ? ST_RDELAY : ST_MEAS;
            dly_cnt <= ratio_ms;
          end else if (tick) begin
            dly_cnt <= dly_cnt - 1'b1;
          end
        end
        ST_RDELAY: begin
          if (dly_cnt == '0) begin
            state <= ST_MEAS;
          end else if (tick) begin
            dly_cnt <= dly_cnt - 1'b1;
          end
        end
        ST_MEAS: begin
          if (MEAS_DONE) begin
            state <= ST_STORE;
          end
        end
        ST_STORE: begin
          idx <= next_idx;
          if (full_pass && sample != 6'h01) begin
            sample  <= sample - 1'b1;
            state   <= ST_DELAY;
            dly_cnt <= user_ms;
          end else begin
            sample     <= list_len;
            first_pass <= 1'b0;
            manual_trigger_key_left  <= manual_trigger_key_left - 1'b1;
            if (count_done) begin
              state <= ST_IDLE;
              if (full_pass) begin
                idx <= '0;
              end
            end else begin
              state <= ST_SOURCE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      OUT_MANUAL_TRIGGER_KEY     <= 1'b0;
      STORE        <= 1'b0;
      MEAS_START   <= 1'b0;
      FILTER_START <= 1'b0;
    end else begin
      STORE        <= state == ST_STORE;
      OUT_MANUAL_TRIGGER_KEY     <= state == ST_STORE && (!full_pass || sample == 6'h01);
      MEAS_START   <= state != ST_MEAS && next_state_meas();
      FILTER_START <= state == ST_MEAS && MEAS_DONE && filter_en;
    end
  end

  function automatic logic next_state_meas();
    return (state == ST_DELAY || state == ST_TIMER || state == ST_RDELAY) &&
           dly_cnt == '0 && (state == ST_RDELAY || !ratio_en);
  endfunction

  // the listed channel stays closed between readings; idle keeps it closed
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      RELAY <= '0;
    end else begin
      RELAY.chan  <= list_mem[idx];
      RELAY.close <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  AST_IDLE_TO_SOURCE: assert property (@(posedge SYS_CLK) disable iff (RST)
    state == ST_IDLE && start_req && !stop_req |=> state == ST_SOURCE)
    else $error("start did not reach source wait");
  AST_EXT_HOLDS: assert property (@(posedge SYS_CLK) disable iff (RST)
    state == ST_SOURCE && src == SRC_EXT && !ext_evt && !mtrig_req && !stop_req
    |=> state == ST_SOURCE)
    else $error("external source left without event");
  AST_IMM_PASSES: assert property (@(posedge SYS_CLK) disable iff (RST)
    state == ST_SOURCE && src == SRC_IMM && !stop_req |=> state == ST_DELAY)
    else $error("immediate source stalled");
  AST_BYPASS: assert property (@(posedge SYS_CLK) disable iff (RST)
    state == ST_SOURCE && src == SRC_TIMER && first_pass && !stop_req
    |=> state == ST_DELAY)
    else $error("timer not bypassed on first pass");
  AST_STEP_PULSE: assert property (@(posedge SYS_CLK) disable iff (RST)
    state == ST_STORE && !full_pass && !stop_req |=> OUT_MANUAL_TRIGGER_KEY)
    else $error("step pulse missing");
  AST_PASS_NO_PULSE: assert property (@(posedge SYS_CLK) disable iff (RST)
    state == ST_STORE && full_pass && sample != 6'h01 |=> !OUT_MANUAL_TRIGGER_KEY)
    else $error("pulse inside a pass");
  AST_IDX_ADV: assert property (@(posedge SYS_CLK) disable iff (RST)
    state == ST_STORE && !full_pass && !stop_req |=> idx == $past(next_idx))
    else $error("list index did not advance");
  AST_END_IDLE: assert property (@(posedge SYS_CLK) disable iff (RST)
    state == ST_STORE && count_done && (!full_pass || sample == 6'h01)
    |=> state == ST_IDLE)
    else $error("count end did not idle");
  AST_UNBOUNDED: assert property (@(posedge SYS_CLK) disable iff (RST)
    state == ST_STORE && unbounded_count && !stop_req |=> state != ST_IDLE)
    else $error("unbounded scan stopped");
  AST_RELAY_CLOSED: assert property (@(posedge SYS_CLK) disable iff (RST)
    state != ST_IDLE |=> RELAY.close && RELAY.chan == $past(list_mem[idx]))
    else $error("relay not on listed channel during scan");

  COV_STEP: cover property (@(posedge SYS_CLK) disable iff (RST)
    state == ST_STORE && !full_pass ##1 state == ST_SOURCE);
  COV_PASS_END: cover property (@(posedge SYS_CLK) disable iff (RST)
    OUT_MANUAL_TRIGGER_KEY && full_pass);
  COV_TIMER: cover property (@(posedge SYS_CLK) disable iff (RST) state == ST_TIMER);
  COV_RATIO: cover property (@(posedge SYS_CLK) disable iff (RST) state == ST_RDELAY);

endmodule

`default_nettype wire

//--- verification/scan_far_side.sv
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// measuring engine and trigger source seen from the sequencer
module scan_far_side (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic meas_start,
  input  wire logic slow,
  input  wire logic fire,
  output logic      meas_done,
  output logic      ext_manual_trigger_key
);
  int left;

  // slow mode stalls the sequencer well past its own pipeline depth
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      left      <= 0;
      meas_done <= 1'b0;
    end else begin
      meas_done <= 1'b0;
      if (meas_start) begin
        left <= slow ? 17 : 1;
      end else if (left == 1) begin
        left      <= 0;
        meas_done <= 1'b1;
      end else if (left > 1) begin
        left <= left - 1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ext_manual_trigger_key <= 1'b0;
    end else begin
      ext_manual_trigger_key <= fire;
    end
  end
endmodule
`default_nettype wire

//--- verification/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  import scan_seq_pkg::*;
  logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr, er;
  logic        ext_manual_trigger_key, meas_done, slow, fire, out_manual_trigger_key, meas_start, filter_start, store;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rv;
  relay_s      relay;
  int          err_count, compares, n_meas, n_store, n_out, n_filt, i;
  logic [7:0]  chans[$];
  logic [7:0]  list[4] = '{8'h11, 8'h14, 8'h13, 8'h12};

  scan_trigger_sequencer scan_trigger_sequencer_inst (.SYS_CLK(sys_clk), .RST(rst),
    .PADDR(paddr), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .EXT_MANUAL_TRIGGER_KEY(ext_manual_trigger_key),
    .OUT_MANUAL_TRIGGER_KEY(out_manual_trigger_key), .RELAY(relay), .MEAS_START(meas_start),
    .FILTER_START(filter_start), .MEAS_DONE(meas_done), .STORE(store));
  scan_far_side scan_far_side_inst (.sys_clk(sys_clk), .rst(rst), .meas_start(meas_start),
    .slow(slow), .fire(fire), .meas_done(meas_done), .ext_manual_trigger_key(ext_manual_trigger_key));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (meas_start === 1'b1) begin
      chans.push_back(relay.chan);
      n_meas++;
    end
    if (store === 1'b1) n_store++;
    if (out_manual_trigger_key === 1'b1) n_out++;
    if (filter_start === 1'b1) n_filt++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", s, e, g);
      err_count++;
    end
  endtask

  // caller enters just after a rising edge; one idle edge keeps psel from double assignment
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // only the watchdog ends a stalled access
    do @(posedge sys_clk); while (pready !== 1'b1);
    rv = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wait_idle;
    int k;
    for (k = 0; k < 3000; k++) begin
      xfer(1'b0, A_STATUS, 32'h0);
      if (rv[0] === 1'b0) break;
    end
    chk("idle", 32'h0, 32'(rv[0]));
  endtask

  task automatic clr;
    n_meas  = 0;
    n_store = 0;
    n_out   = 0;
    n_filt  = 0;
    chans.delete();
  endtask

  function automatic logic [31:0] ctl(input logic full, input logic [1:0] src,
                                      input logic [2:0] opt);
    return (32'(full) << C_FULL) | (32'(src) << C_SRC) | (32'(opt) << C_MANUAL);
  endfunction

  task automatic scan(input logic [31:0] c, input logic [31:0] rdg, input int first,
                      input int exp_n, input int exp_out, input string name);
    int k;
    clr();
    xfer(1'b1, A_RDGCNT, rdg);
    xfer(1'b1, A_CTRL, c | 32'h1);
    wait_idle();
    chk("readings", 32'(exp_n), 32'(n_store));
    chk("out_manual_trigger_key", 32'(exp_out), 32'(n_out));
    for (k = 0; k < exp_n; k++) begin
      chk("chan", 32'(list[(first + k) % 4]), 32'(chans[k]));
    end
    $display("test %s done", name);
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge sys_clk);
    err_count++;
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, slow, fire} = '0;
    paddr  = 8'h00;
    pwdata = 32'h0;
    rst    = 1'b1;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    xfer(1'b0, A_RDELAY, 32'h0);
    chk("ratio_delay", 32'h1f4, rv);
    xfer(1'b0, A_LISTLEN, 32'h0);
    chk("list_len", 32'h1, rv);
    xfer(1'b0, 8'he0, 32'h0);
    chk("slverr_hi", 32'h1, 32'(er));
    xfer(1'b0, 8'hdc, 32'h0);
    chk("slverr_lo", 32'h0, 32'(er));
    $display("test registers done");
    for (i = 0; i < 4; i++) begin
      xfer(1'b1, 8'(A_LIST + 8'(4 * i)), 32'(list[i]));
    end
    xfer(1'b1, A_LISTLEN, 32'h4);
    xfer(1'b1, A_LISTLEN, 32'h44);
    xfer(1'b0, A_LISTLEN, 32'h0);
    chk("list_len_keep", 32'h4, rv);
    xfer(1'b1, A_CTRL, ctl(1'b1, SRC_EXT, 3'b101));
    xfer(1'b0, A_CTRL, 32'h0);
    chk("ctrl", 32'hb4, rv);
    xfer(1'b1, A_MDELAY, 32'hffffffff);
    xfer(1'b0, A_MDELAY, 32'h0);
    chk("manual_max", 32'h159a653f, rv);
    xfer(1'b1, A_TIMER, 32'h0);
    xfer(1'b1, A_MDELAY, 32'h0);
    xfer(1'b1, A_ADELAY, 32'h0);
    xfer(1'b1, A_RDELAY, 32'h0);
    scan(ctl(1'b0, SRC_IMM, 3'b000), 32'h2, 0, 2, 2, "step");
    scan(ctl(1'b0, SRC_IMM, 3'b000), 32'h3, 2, 3, 3, "resume");
    slow <= 1'b1;
    scan(ctl(1'b1, SRC_IMM, 3'b000), 32'h5, 0, 8, 2, "full");
    chk("rest_chan", 32'(list[0]), 32'(relay.chan));
    chk("rest_close", 32'h1, 32'(relay.close));
    scan(ctl(1'b1, SRC_TIMER, 3'b001), 32'h8, 0, 8, 2, "timer");
    scan(ctl(1'b1, SRC_IMM, 3'b110), 32'h4, 0, 4, 1, "filter");
    chk("filter_runs", 32'h4, 32'(n_filt));
    clr();
    xfer(1'b1, A_RDGCNT, 32'h8);
    xfer(1'b1, A_CTRL, ctl(1'b1, SRC_EXT, 3'b000) | 32'h1);
    repeat (40) @(posedge sys_clk);
    chk("no_event", 32'h0, 32'(n_meas));
    fire <= 1'b1;
    repeat (4) @(posedge sys_clk);
    fire <= 1'b0;
    for (i = 0; i < 800 && n_out < 1; i++) @(posedge sys_clk);
    repeat (40) @(posedge sys_clk);
    chk("one_pass", 32'h4, 32'(n_store));
    xfer(1'b1, A_CTRL, ctl(1'b1, SRC_EXT, 3'b000) | (32'h1 << C_MTRIG));
    wait_idle();
    chk("key_pass", 32'h8, 32'(n_store));
    chk("key_manual_trigger_key", 32'h2, 32'(n_out));
    $display("test external done");
    slow <= 1'b0;
    clr();
    xfer(1'b1, A_RDGCNT, 32'h0);
    xfer(1'b1, A_CTRL, ctl(1'b0, SRC_IMM, 3'b000) | 32'h1);
    for (i = 0; i < 800 && n_meas < 10; i++) @(posedge sys_clk);
    xfer(1'b0, A_STATUS, 32'h0);
    chk("endless_busy", 32'h1, 32'(rv[0]));
    xfer(1'b1, A_CTRL, 32'h1 << C_STOP);
    xfer(1'b0, A_STATUS, 32'h0);
    chk("stopped", 32'h0, 32'(rv[0]));
    $display("test unbounded done");
    stop_test();
  end
endmodule
`default_nettype wire
